// ### verilog/fcok_top.sv
// Flash clock divider, option image and backdoor key logic.
// Assumes bus clock clk, synchronous active-low reset, Avalon-MM slave,
// option bytes and stored key presented by the flash array at reset.
//
// Contract
// R1 - Loaded flag read-only, cleared by reset, set by first divider write.
// R2 - Divider low seven bits always readable, written once after reset.
// R3 - Erase and program refused until loaded flag set.
// R4 - Prescale bit one feeds divider with bus clock over eight.
// R5 - Divider divides its input by ratio field plus one.
// R6 - Software keeps flash clock within 150 to 200 kHz.
// R7 - Timing pulse lasts one flash clock; operations count whole pulses.
// R8 - Option byte copied at reset; changes apply only after next reset.
// R9 - Backdoor disabled option bit forbids any key unlock.
// R10 - Key writes from debug commands never count as key values.
// R11 - Matching eight-byte ordered key drops security until reset.
// R12 - Remap-off option bit disables vector redirection when one.
// R13 - Only security code 1:0 means unsecured.
// R14 - While secured, unsecured sources are blocked from RAM and flash.
// R15 - Security code becomes 1:0 after key match or blank check pass.
// R16 - Compare-select zero routes key writes to command start.
// R17 - Compare-select one captures key writes as comparison values.
// R18 - Clearing compare-select compares captured key, unsecures on match.
// R19 - Firmware writes keys ascending, never on adjacent bus cycles.
// R20 - Erase or program before divider write sets error, command ignored.
// R21 - Software writes to option image have no effect.
`default_nettype none
module fcok_top #(
    parameter int RATIO_BITS = 6
) (
    input wire logic clk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Flash side
    input wire logic [7:0] option_source_byte,
    input wire logic [63:0] stored_unlock_code,
    input wire fcok_pkg::fcok_keywr_t key_write,
    input wire logic prog_erase_req,
    input wire logic blank_check_pass,
    input wire logic access_from_unsecured,
    output logic prog_erase_go,
    output logic command_start,
    output logic sequence_error_flag,
    output logic flash_tick,
    output logic vector_remap_off,
    output logic secured,
    output logic access_block
);
    // ==========================================================
    // Registers
    logic ratio_loaded_flag_reg;
    logic prescale_by_eight_reg;
    logic [RATIO_BITS-1:0] ratio_div_reg;
    fcok_pkg::fcok_opt_t opt_reg;
    logic opt_loaded_reg;
    logic compare_write_select_reg;
    logic [7:0] key_cap_reg [fcok_pkg::FCOK_KEY_BYTES];
    logic [2:0] key_next_idx_reg;
    logic key_order_ok_reg;
    logic key_order_err_reg;
    logic ack_reg;
    logic [2:0] pre_cnt_reg;
    logic [RATIO_BITS-1:0] div_cnt_reg;
    logic [63:0] key_flat;
    logic wr_ratio, wr_cfg, key_match, pre_tick;

    // ==========================================================
    // Bus decode; one wait state so read data comes from a flop
    // Writes land on the edge where waitrequest is low, when the master completes
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign wr_ratio = avs_write & ack_reg & avs_byteenable[0] & (avs_address == fcok_pkg::FCOK_OFS_RATIO);
    assign wr_cfg = avs_write & ack_reg & avs_byteenable[0] & (avs_address == fcok_pkg::FCOK_OFS_CFG);

    // Handshake toggle: answer on the cycle after a request appears
    always_ff @(posedge clk) begin
        if (!rst_b) ack_reg <= 1'b0;
        else ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end

    // Read mux, unmapped offsets return zero
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read & ~ack_reg) begin
            case (avs_address)
                fcok_pkg::FCOK_OFS_RATIO: avs_readdata <= {24'h00_0000, ratio_loaded_flag_reg,
                    prescale_by_eight_reg, 6'(ratio_div_reg)}; // [R1] [R2]
                fcok_pkg::FCOK_OFS_OPT: avs_readdata <= {24'h00_0000, opt_reg};
                fcok_pkg::FCOK_OFS_CFG: avs_readdata <= {26'h000_0000, compare_write_select_reg, 5'h00};
                fcok_pkg::FCOK_OFS_KEYCMP: avs_readdata <= {30'h0000_0000, key_order_err_reg, key_match};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // Divider register: write once, flag set whatever the data
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ratio_loaded_flag_reg <= 1'b0; // [R1]
            prescale_by_eight_reg <= fcok_pkg::FCOK_RATIO_RST[6];
            ratio_div_reg <= RATIO_BITS'(fcok_pkg::FCOK_RATIO_RST);
        end else if (wr_ratio && !ratio_loaded_flag_reg) begin
            ratio_loaded_flag_reg <= 1'b1; // [R1]
            prescale_by_eight_reg <= avs_writedata[fcok_pkg::FCOK_RATIO_PRESCALE_BIT]; // [R2]
            ratio_div_reg <= avs_writedata[RATIO_BITS-1:0]; // [R2]
        end
    end

    // ==========================================================
    // Flash clock: optional divide by 8, then divide by ratio+1
    assign pre_tick = prescale_by_eight_reg ? (pre_cnt_reg == fcok_pkg::FCOK_PRESCALE_LAST) : 1'b1; // [R4]

    always_ff @(posedge clk) begin
        if (!rst_b) pre_cnt_reg <= 3'h0;
        else pre_cnt_reg <= pre_cnt_reg + 3'h1; // [R4]
    end

    // Tick is one bus cycle wide; sequencer counts ticks as pulses
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            div_cnt_reg <= '0;
            flash_tick <= 1'b0;
        end else begin
            flash_tick <= 1'b0;
            if (pre_tick) begin
                if (div_cnt_reg >= ratio_div_reg) begin
                    div_cnt_reg <= '0;
                    flash_tick <= 1'b1; // [R5] [R7]
                end else begin
                    div_cnt_reg <= div_cnt_reg + RATIO_BITS'(1); // [R5]
                end
            end
        end
    end

    // ==========================================================
    // Erase/program gate; refused requests flag a sequence error
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prog_erase_go <= 1'b0;
            sequence_error_flag <= 1'b0;
        end else begin
            prog_erase_go <= prog_erase_req & ratio_loaded_flag_reg; // [R3]
            sequence_error_flag <= prog_erase_req & ~ratio_loaded_flag_reg; // [R20]
        end
    end

    // ==========================================================
    // Option image: copied once after reset, bus writes ignored
    // Copy is clocked after release so no port feeds the reset value
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            opt_reg <= '0;
            opt_loaded_reg <= 1'b0;
        end else if (!opt_loaded_reg) begin
            opt_reg <= option_source_byte; // [R8] [R21]
            opt_loaded_reg <= 1'b1;
        end else if ((key_match && wr_cfg && compare_write_select_reg
                && !avs_writedata[fcok_pkg::FCOK_CFG_CMPSEL_BIT]
                && opt_reg.backdoor_unlock_allow) || blank_check_pass) begin
            opt_reg.protection_state_code <= fcok_pkg::FCOK_SEC_OPEN; // [R9] [R15] [R18]
        end
    end

    assign secured = !opt_loaded_reg || (opt_reg.protection_state_code != fcok_pkg::FCOK_SEC_OPEN); // [R13]
    assign access_block = secured & access_from_unsecured; // [R14]
    assign vector_remap_off = opt_reg.vector_remap_off; // [R12]

    // ==========================================================
    // Configuration register
    always_ff @(posedge clk) begin
        if (!rst_b) compare_write_select_reg <= 1'b0;
        else if (wr_cfg) compare_write_select_reg <= avs_writedata[fcok_pkg::FCOK_CFG_CMPSEL_BIT];
    end

    // Key writes start a command unless compare-select is set
    always_ff @(posedge clk) begin
        if (!rst_b) command_start <= 1'b0;
        else command_start <= key_write.valid & ~compare_write_select_reg; // [R16]
    end

    // ==========================================================
    // Key capture; order is checked, debug writes do not count
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            key_next_idx_reg <= 3'h0;
            key_order_ok_reg <= 1'b0;
            key_order_err_reg <= 1'b0;
            for (int i = 0; i < fcok_pkg::FCOK_KEY_BYTES; i++) key_cap_reg[i] <= 8'h00;
        end else if (wr_cfg && avs_writedata[fcok_pkg::FCOK_CFG_CMPSEL_BIT] && !compare_write_select_reg) begin
            key_next_idx_reg <= 3'h0;
            key_order_ok_reg <= 1'b0;
            key_order_err_reg <= 1'b0;
        end else if (key_write.valid && compare_write_select_reg && !key_write.from_debug) begin // [R10] [R17]
            key_cap_reg[key_write.index] <= key_write.data; // [R17]
            key_next_idx_reg <= key_write.index + 3'h1;
            if (key_write.index != key_next_idx_reg) key_order_err_reg <= 1'b1; // [R11]
            key_order_ok_reg <= (key_write.index == 3'h7) && !key_order_err_reg
                && (key_write.index == key_next_idx_reg); // [R11]
        end
    end

    // Captured bytes flattened, first key byte in the top lane
    always_comb begin
        key_flat = 64'h0000_0000_0000_0000;
        for (int i = 0; i < fcok_pkg::FCOK_KEY_BYTES; i++) key_flat[63-8*i -: 8] = key_cap_reg[i];
    end
    assign key_match = key_order_ok_reg && (key_flat == stored_unlock_code); // [R11] [R18]

endmodule : fcok_top
`default_nettype wire

// ### verilog/fcok_pkg.sv
// Package for the flash clock, option and key configuration block.
// Assumes a single bus clock domain and an Avalon-MM register slave.
`default_nettype none
package fcok_pkg;
    // ==========================================================
    // Register word offsets (byte addresses, one word each)
    localparam logic [3:0] FCOK_OFS_RATIO = 4'h0;
    localparam logic [3:0] FCOK_OFS_OPT = 4'h4;
    localparam logic [3:0] FCOK_OFS_CFG = 4'h8;
    localparam logic [3:0] FCOK_OFS_KEYCMP = 4'hC;
    // ==========================================================
    // Field positions
    localparam int FCOK_RATIO_LOADED_BIT = 7;
    localparam int FCOK_RATIO_PRESCALE_BIT = 6;
    localparam int FCOK_OPT_UNLOCK_BIT = 7;
    localparam int FCOK_OPT_REMAP_BIT = 6;
    localparam int FCOK_CFG_CMPSEL_BIT = 5;
    localparam int FCOK_KEYCMP_ERR_BIT = 1;
    // ==========================================================
    // Reset values and codes
    localparam logic [6:0] FCOK_RATIO_RST = 7'h00;
    localparam logic [1:0] FCOK_SEC_OPEN = 2'h2;
    localparam logic [2:0] FCOK_PRESCALE_LAST = 3'h7;
    localparam int FCOK_KEY_BYTES = 8;
    // ==========================================================
    // Option image fields
    typedef struct packed {
        logic backdoor_unlock_allow;
        logic vector_remap_off;
        logic [3:0] unused_bits;
        logic [1:0] protection_state_code;
    } fcok_opt_t;
    // Write path toward key locations
    typedef struct packed {
        logic valid;
        logic from_debug;
        logic [2:0] index;
        logic [7:0] data;
    } fcok_keywr_t;
endpackage : fcok_pkg
`default_nettype wire

// ### test/fcok_monitor.sv
// Checker for fcok_top: bus handshake, command and security relations.
// Assumes the bind below and one clock domain.
`default_nettype none
module fcok_monitor #(
    parameter int RATIO_BITS = 6
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire fcok_pkg::fcok_keywr_t key_write,
    input wire logic prog_erase_req,
    input wire logic access_from_unsecured,
    input wire logic prog_erase_go,
    input wire logic command_start,
    input wire logic sequence_error_flag,
    input wire logic secured,
    input wire logic access_block
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Relations; all in the bus clock domain
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    wait_first_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest) else $error("no wait");
    wait_end_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait too long");
    block_src_a: assert property (access_block == (secured && access_from_unsecured)) else $error("block");
    req_outcome_a: assert property (prog_erase_req |=> prog_erase_go != sequence_error_flag)
        else $error("request outcome");
    go_cause_a: assert property (prog_erase_go |-> $past(prog_erase_req)) else $error("stray go");
    err_cause_a: assert property (sequence_error_flag |-> $past(prog_erase_req)) else $error("stray error");
    start_cause_a: assert property (command_start |-> $past(key_write.valid)) else $error("stray start");
    unsec_hold_a: assert property (!secured |=> !secured) else $error("security came back");
    // Main scenarios seen
    cover property (prog_erase_go);
    cover property (sequence_error_flag);
    cover property ($fell(secured));
endmodule : fcok_monitor
bind fcok_top fcok_monitor #(.RATIO_BITS(RATIO_BITS)) u_mon (.clk(clk), .rst_b(rst_b), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .key_write(key_write),
    .prog_erase_req(prog_erase_req), .access_from_unsecured(access_from_unsecured), .secured(secured),
    .prog_erase_go(prog_erase_go), .command_start(command_start), .access_block(access_block),
    .sequence_error_flag(sequence_error_flag));
`default_nettype wire

// ### test/fcok_host_model.sv
// Model of the CPU, debug port and flash storage around the block.
// Assumes its tasks are called from the bench's clocked sequence.
`default_nettype none
module fcok_host_model (
    input wire logic clk,
    input wire logic [7:0] opt,
    output logic [7:0] option_source_byte,
    output logic [63:0] stored_unlock_code,
    output var fcok_pkg::fcok_keywr_t key_write,
    output logic prog_erase_req,
    output logic blank_check_pass
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Flash contents; the key value is arbitrary
    assign option_source_byte = opt;
    assign stored_unlock_code = 64'h5A3C_91E7_0F42_B86D;
    initial begin
        key_write = '0;
        prog_erase_req = 1'b0;
        blank_check_pass = 1'b0;
    end
    // One-cycle pulse: 0 erase or program request, 1 blank pass
    task automatic pulse(input int which);
        @(posedge clk);
        prog_erase_req <= (which == 0);
        blank_check_pass <= (which == 1);
        @(posedge clk);
        prog_erase_req <= 1'b0;
        blank_check_pass <= 1'b0;
    endtask : pulse
    // Key write; next call leaves an idle cycle, never adjacent
    task automatic key(input logic [2:0] idx, input logic dbg, input logic [7:0] d);
        @(posedge clk);
        key_write <= '{1'b1, dbg, idx, d};
        @(posedge clk);
        key_write <= '{1'b0, 1'b0, ~idx, ~d}; // No stale value after release
    endtask : key
endmodule : fcok_host_model
`default_nettype wire

// ### test/tb.sv
// Self-checking bench for fcok_top over three resets.
// Assumes fcok_host_model supplies option byte, key and pulses.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_b = 0, rd = 0, wr = 0, afu = 0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wd = 32'h0, rq, rdata;
    logic [7:0] opt = 8'h00, q;
    logic [7:0] opts [3] = '{8'h83, 8'h41, 8'hC2};
    logic wq, go, cs, err, tk, rmo, sec, pe, bc, blk;
    logic [7:0] osb;
    logic [63:0] key;
    fcok_pkg::fcok_keywr_t kw;
    int n_fail = 0, tests_run = 0, g, r, exp_sec;
    always #2 clk = ~clk;
    always @(posedge clk) afu <= 1'($urandom_range(1, 0));
    fcok_top u_dut (.clk(clk), .rst_b(rst_b), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(rq), .avs_waitrequest(wq),
        .option_source_byte(osb), .stored_unlock_code(key), .key_write(kw), .prog_erase_req(pe),
        .blank_check_pass(bc), .access_from_unsecured(afu), .prog_erase_go(go), .command_start(cs),
        .sequence_error_flag(err), .flash_tick(tk), .vector_remap_off(rmo), .secured(sec), .access_block(blk));
    fcok_host_model u_p (.clk(clk), .opt(opt), .option_source_byte(osb), .stored_unlock_code(key),
        .key_write(kw), .prog_erase_req(pe), .blank_check_pass(bc));
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %0t %s", $time, m);
        end
    endtask : chk
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    // Avalon cycle: hold until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [31:0] v);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= {24'h0, d};
        @(posedge clk);
        while (wq !== 1'b0) begin
            n++;
            if (n > 20)
                conclude_hang();
            @(posedge clk);
        end
        v = rq;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic conclude_hang;
        n_fail++;
        conclude();
    endtask : conclude_hang
    // Cycles from one flash tick to the next, bounded
    task automatic tick_gap(output int gap);
        int n;
        n = 0;
        while (tk !== 1'b1 && n < 2000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 2000)
            conclude_hang();
        gap = 0;
        do begin
            @(posedge clk);
            gap++;
        end while (tk !== 1'b1 && gap < 2000);
        if (gap >= 2000)
            conclude_hang();
    endtask : tick_gap
    // ==========================================================
    // Main sequence: one pass per reset and option byte
    initial begin
        void'($urandom(32'h73CC));
        for (int i = 0; i < 3; i++) begin
            q = opts[i];
            if (i == 1)
                q[0] = 1'($urandom_range(1, 0));
            @(posedge clk);
            opt <= q;
            rst_b <= 1'b0;
            repeat (8) @(posedge clk);
            rst_b <= 1'b1;
            repeat (2) @(posedge clk);
            exp_sec = (q[1:0] != 2'h2);
            chk(sec, exp_sec, "secured at reset");
            chk(blk, exp_sec & afu, "access block");
            chk(rmo, q[6], "remap bit");
            bus(0, fcok_pkg::FCOK_OFS_OPT, 0, rdata);
            chk(rdata, q, "option image");
            bus(1, fcok_pkg::FCOK_OFS_OPT, ~q, rdata);
            bus(0, fcok_pkg::FCOK_OFS_OPT, 0, rdata);
            chk(rdata, q, "option written");
            bus(0, fcok_pkg::FCOK_OFS_RATIO, 0, rdata);
            chk(rdata, 0, "ratio at reset");
            u_p.pulse(0);
            @(posedge clk);
            chk({go, err}, 2'b01, "unloaded request");
            r = $urandom_range(7, 0);
            // Small ratios keep runs short; the real kHz window is out of reach at this bus rate
            bus(1, fcok_pkg::FCOK_OFS_RATIO, {1'b0, i[0], 6'(r)}, rdata);
            bus(1, fcok_pkg::FCOK_OFS_RATIO, 8'h3F, rdata);
            bus(0, fcok_pkg::FCOK_OFS_RATIO, 0, rdata);
            chk(rdata, {1'b1, i[0], 6'(r)}, "ratio once");
            u_p.pulse(0);
            @(posedge clk);
            chk({go, err}, 2'b10, "loaded request");
            tick_gap(g);
            chk(g, (r + 1) * (i[0] ? 8 : 1), "tick period");
            bus(1, fcok_pkg::FCOK_OFS_CFG, 8'h00, rdata);
            u_p.key(0, 0, key[63:56]);
            @(posedge clk);
            chk(cs, 1, "command start");
            bus(1, fcok_pkg::FCOK_OFS_CFG, 8'h20, rdata);
            u_p.key(0, 1, ~key[63:56]);
            for (int k = 0; k < 8; k++) begin
                u_p.key(k[2:0], 0, key[63 - 8 * k -: 8]);
                @(posedge clk);
                chk(cs, 0, "captured key");
            end
            bus(0, fcok_pkg::FCOK_OFS_KEYCMP, 0, rdata);
            chk(rdata, 1, "key status");
            bus(1, fcok_pkg::FCOK_OFS_CFG, 8'h00, rdata);
            repeat (2) @(posedge clk);
            if (q[7])
                exp_sec = 0;
            chk(sec, exp_sec, "key unlock");
            u_p.pulse(1);
            repeat (2) @(posedge clk);
            chk(sec, 0, "blank unlock");
            chk(blk, 0, "access open");
            $display("test %0d done", i);
        end
        conclude();
    end
endmodule : tb
`default_nettype wire
